// ### hw/out_packet_tracker.sv
`timescale 1ns/1ps
`include "usb_out_consts.svh"

module out_packet_tracker
    import usb_out_pkg::*;
(
    input  wire logic       sys_clk,     // Core clock
    input  wire logic       rst,         // Async reset, active high
    input  wire logic       double_buf,  // Two packet slots when high
    input  wire logic       push,        // Packet stored in FIFO
    input  wire logic       pop,         // Oldest packet released
    output logic [1:0]      pkt_count,   // Packets held
    output logic            full         // No room for another packet
);

    tracker_state_t s_q;
    tracker_state_t s_d;

    // Full depends on the buffering mode
    assign pkt_count = s_q.count;
    assign full      = double_buf ? (s_q.count > `PKT_CNT_ONE)
                                  : (s_q.count != `PKT_CNT_ZERO); // R10

    // Count up on store, down on release; both at once leaves it alone
    always_comb begin
        s_d = s_q;
        if (push && !full && !(pop && s_q.count != `PKT_CNT_ZERO)) begin
            s_d.count = s_q.count + `PKT_CNT_ONE;
        end else if (pop && !(push && !full) && s_q.count != `PKT_CNT_ZERO) begin
            s_d.count = s_q.count - `PKT_CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : out_packet_tracker

// ### hw/usb_out_consts.svh
`ifndef USB_OUT_CONSTS_SVH
`define USB_OUT_CONSTS_SVH

// Register byte offsets on the Avalon slave
`define OFF_CTRL_LOW       8'h14
`define OFF_CTRL_HIGH      8'h18
`define OFF_INT_STATUS     8'h20
`define OFF_INT_CLEAR      8'h24
`define OFF_INT_ENABLE     8'h28

// Low control byte fields
`define BIT_CLR_TOGGLE     7
`define BIT_STALL_SENT     6
`define BIT_STALL_REQ      5
`define BIT_FLUSH          4
`define BIT_DATA_ERR       3
`define BIT_OVERRUN        2
`define BIT_FIFO_FULL      1
`define BIT_PKT_READY      0

// High control byte fields
`define BIT_DOUBLE_BUF     7
`define BIT_ISO_EN         6

// Interrupt status / clear / enable fields
`define INT_W              3
`define INT_PKT_READY      0
`define INT_STALL          1
`define INT_OVERRUN        2
`define INT_RESET          3'h0

// Packet counter
`define PKT_CNT_W          2
`define PKT_CNT_ZERO       2'h0
`define PKT_CNT_ONE        2'h1

`endif

// ### hw/usb_out_endpoint_status_ctrl.sv
`timescale 1ns/1ps
`include "usb_out_consts.svh"

// Overview of operation
// R1 - Writing one to clear-toggle zeroes the data toggle; strobe always reads zero.
// R2 - Stall-sent flag sets on every transmitted STALL, stays until software clears.
// R3 - Stall request makes the endpoint answer STALL while set.
// R4 - Each flush write of one discards only the next waiting packet.
// R5 - A flush resets the FIFO read pointer and clears out-packet-ready.
// R6 - Flush bit returns to zero by itself when the flush completes.
// R7 - Software should not flush a partly read packet; drain it by reading.
// R8 - ISO only: data-error sets on CRC or stuffing error, clears with packet-ready.
// R9 - ISO only: overrun sets when a packet is lost to a full FIFO.
// R10 - FIFO-full means two packets double buffered, one packet single buffered.
// R11 - Packet-ready sets when a packet is waiting; software clears after unloading.
// R12 - Interrupt raised when packet-ready sets and when a STALL is generated.
// R13 - ISO mode selected by the ISO enable bit; bulk and interrupt alike otherwise.
// R14 - Writing zero to clear-toggle or flush changes nothing.

module usb_out_endpoint_status_ctrl
    import usb_out_pkg::*;
#(
    parameter int ADDR_W = 8                          // Avalon byte address width
)(
    input  wire logic              sys_clk,           // Core clock, 250 MHz
    input  wire logic              rst,               // Async reset, active high
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address,       // Byte address
    input  wire logic              avs_read,          // Read request
    input  wire logic              avs_write,         // Write request
    input  wire logic [31:0]       avs_writedata,     // Write data
    input  wire logic [3:0]        avs_byteenable,    // Byte lanes
    output logic [31:0]            avs_readdata,      // Read data
    output logic                   avs_waitrequest,   // Stall the master
    // Serial engine side
    input  wire logic              rx_pkt_valid,      // OUT data packet ended
    input  wire logic              rx_pkt_crc_err,    // With CRC or stuffing error
    input  wire logic              tx_stall_done,     // STALL handshake sent
    input  wire logic              toggle_advance,    // Toggle flips on good packet
    output logic                   send_stall,        // Answer tokens with STALL
    output logic                   data_toggle,       // Expected DATA0/DATA1
    output logic                   iso_mode,          // Isochronous endpoint
    output logic                   accept_packet,     // Room for a packet
    output logic                   fifo_rd_ptr_reset, // Drop next packet, rewind
    output logic                   out_fifo_full,     // FIFO-full indication
    output logic                   irq                // Level interrupt
);

    ctrl_state_t    s_q;
    ctrl_state_t    s_d;
    logic [1:0]     pkt_count;
    logic           pkt_store;
    logic           pkt_pop;
    logic           wr_en;
    logic           wr_low;
    logic           wr_high;
    logic           sw_clr_ready;
    logic           set_ready;
    logic           lost_pkt;
    logic [7:0]     low_byte;
    logic [7:0]     high_byte;
    logic [2:0]     int_events;

    // Address match on word-aligned offsets
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [7:0]        off);
        reg_hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction : reg_hit

    // Packet accounting kept apart so the full rule lives in one place
    out_packet_tracker u_tracker (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .double_buf (s_q.double_buf),
        .push       (pkt_store),
        .pop        (pkt_pop),
        .pkt_count  (pkt_count),
        .full       (out_fifo_full)
    );

    // One wait state: data is latched first, presented on the ack edge
    assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
    assign avs_readdata    = s_q.rdata;
    assign wr_en           = avs_write && s_q.ack && avs_byteenable[0];
    assign wr_low          = wr_en && reg_hit(avs_address, `OFF_CTRL_LOW);
    assign wr_high         = wr_en && reg_hit(avs_address, `OFF_CTRL_HIGH);

    // Writing zero to the ready bit is how software hands a packet back
    assign sw_clr_ready    = wr_low && s_q.pkt_ready
                             && !avs_writedata[`BIT_PKT_READY];                // R11

    // Engine side handshake and status
    assign accept_packet   = !out_fifo_full;
    assign pkt_store       = rx_pkt_valid && !out_fifo_full
                             && (!rx_pkt_crc_err || s_q.iso_en);               // R13
    assign lost_pkt        = rx_pkt_valid && out_fifo_full && s_q.iso_en;     // R9
    assign pkt_pop         = sw_clr_ready || (s_q.fstate == FL_DRAIN
                                              && pkt_count != `PKT_CNT_ZERO); // R4
    assign set_ready       = !s_q.pkt_ready
                             && ((pkt_store && pkt_count == `PKT_CNT_ZERO)
                                 || (s_q.reload && pkt_count != `PKT_CNT_ZERO));

    assign send_stall        = s_q.stall_req;                                 // R3
    assign data_toggle       = s_q.toggle;
    assign iso_mode          = s_q.iso_en;
    assign fifo_rd_ptr_reset = s_q.flush_pulse;                               // R5
    assign irq               = |(s_q.int_status & s_q.int_enable);

    // Register images; clear-toggle reads zero
    always_comb begin
        low_byte = 8'h00;
        low_byte[`BIT_STALL_SENT] = s_q.stall_sent;
        low_byte[`BIT_STALL_REQ]  = s_q.stall_req;
        low_byte[`BIT_FLUSH]      = s_q.flush;
        low_byte[`BIT_DATA_ERR]   = s_q.data_err;
        low_byte[`BIT_OVERRUN]    = s_q.overrun;
        low_byte[`BIT_FIFO_FULL]  = out_fifo_full;
        low_byte[`BIT_PKT_READY]  = s_q.pkt_ready;
        high_byte = 8'h00;
        high_byte[`BIT_DOUBLE_BUF] = s_q.double_buf;
        high_byte[`BIT_ISO_EN]     = s_q.iso_en;
    end

    // Interrupt sources
    always_comb begin
        int_events = `INT_RESET;
        int_events[`INT_PKT_READY] = set_ready;                               // R12
        int_events[`INT_STALL]     = tx_stall_done;                           // R12
        int_events[`INT_OVERRUN]   = lost_pkt;
    end

    // Next state of the whole block
    always_comb begin
        s_d = s_q;
        s_d.flush_pulse = 1'b0;
        s_d.ack         = (avs_read || avs_write) && !s_q.ack;

        // Read data captured in the wait cycle; unmapped reads give zero
        if (avs_read && !s_q.ack) begin
            s_d.rdata = 32'h0000_0000;
            if (reg_hit(avs_address, `OFF_CTRL_LOW)) begin
                s_d.rdata[7:0] = low_byte;                                    // R1
            end else if (reg_hit(avs_address, `OFF_CTRL_HIGH)) begin
                s_d.rdata[7:0] = high_byte;
            end else if (reg_hit(avs_address, `OFF_INT_STATUS)) begin
                s_d.rdata[`INT_W-1:0] = s_q.int_status;
            end else if (reg_hit(avs_address, `OFF_INT_ENABLE)) begin
                s_d.rdata[`INT_W-1:0] = s_q.int_enable;
            end
        end

        // Low control byte writes
        if (wr_low) begin
            s_d.stall_req = avs_writedata[`BIT_STALL_REQ];                    // R3
            if (!avs_writedata[`BIT_STALL_SENT]) begin
                s_d.stall_sent = 1'b0;
            end
            if (!avs_writedata[`BIT_OVERRUN]) begin
                s_d.overrun = 1'b0;
            end
            if (avs_writedata[`BIT_FLUSH]) begin
                s_d.flush = 1'b1;                                             // R14
            end
            if (sw_clr_ready) begin
                s_d.pkt_ready = 1'b0;                                         // R11
                s_d.data_err  = 1'b0;                                         // R8
                s_d.reload    = 1'b1;
            end
        end

        // High control byte: buffering and transfer type
        if (wr_high) begin
            s_d.double_buf = avs_writedata[`BIT_DOUBLE_BUF];
            s_d.iso_en     = avs_writedata[`BIT_ISO_EN];                      // R13
        end

        // Interrupt enable and write-one-to-clear status
        if (wr_en && reg_hit(avs_address, `OFF_INT_ENABLE)) begin
            s_d.int_enable = avs_writedata[`INT_W-1:0];
        end
        if (wr_en && reg_hit(avs_address, `OFF_INT_CLEAR)) begin
            s_d.int_status = s_q.int_status & ~avs_writedata[`INT_W-1:0];
        end

        // Data toggle: flips on good packets, clear strobe wins
        if (toggle_advance) begin
            s_d.toggle = !s_q.toggle;
        end
        if (wr_low && avs_writedata[`BIT_CLR_TOGGLE]) begin
            s_d.toggle = 1'b0;                                                // R1
        end

        // Flush sequence; a packet is dropped one per request
        unique case (s_q.fstate)
            FL_IDLE: begin
                if (s_q.flush) begin
                    s_d.fstate = FL_DRAIN;
                end
            end
            FL_DRAIN: begin
                s_d.flush_pulse = (pkt_count != `PKT_CNT_ZERO);               // R5
                s_d.pkt_ready   = 1'b0;                                       // R5
                s_d.data_err    = 1'b0;
                s_d.reload      = 1'b1;
                s_d.fstate      = FL_DONE;
            end
            FL_DONE: begin
                s_d.flush  = 1'b0;                                            // R6
                s_d.fstate = FL_IDLE;
            end
            default: begin
                s_d.fstate = FL_IDLE;
            end
        endcase

        // Re-arm ready only once the counter has settled after a release
        if (s_q.reload && !pkt_pop && s_q.fstate != FL_DRAIN) begin
            s_d.reload = 1'b0;
        end

        // Hardware sets placed last so a same-cycle clear loses, except ready, which loses to the flush drain clear
        if (set_ready && s_q.fstate != FL_DRAIN) begin
            s_d.pkt_ready = 1'b1;                                             // R11
        end
        if (pkt_store && rx_pkt_crc_err && s_q.iso_en) begin
            s_d.data_err = 1'b1;                                              // R8
        end
        if (lost_pkt) begin
            s_d.overrun = 1'b1;                                               // R9
        end
        if (tx_stall_done) begin
            s_d.stall_sent = 1'b1;                                            // R2
        end
        s_d.int_status = s_d.int_status | int_events;
    end

    // Single state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : usb_out_endpoint_status_ctrl

// ### hw/usb_out_pkg.sv
package usb_out_pkg;

    typedef enum logic [1:0] {
        FL_IDLE  = 2'b00,
        FL_DRAIN = 2'b01,
        FL_DONE  = 2'b10
    } flush_state_t;

    typedef struct packed {
        logic [1:0] count;
    } tracker_state_t;

    typedef struct packed {
        logic         toggle;
        logic         stall_sent;
        logic         stall_req;
        logic         flush;
        logic         data_err;
        logic         overrun;
        logic         pkt_ready;
        logic         reload;
        logic         double_buf;
        logic         iso_en;
        flush_state_t fstate;
        logic         flush_pulse;
        logic [2:0]   int_status;
        logic [2:0]   int_enable;
        logic         ack;
        logic [31:0]  rdata;
    } ctrl_state_t;

endpackage : usb_out_pkg

// ### tb/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
    input  wire logic sys_clk,        // Clock
    input  wire logic rst,            // Reset
    input  wire logic send_stall,     // Endpoint stalled
    input  wire logic accept_packet,  // Room in FIFO
    input  wire logic go,             // One OUT transfer asked
    input  wire logic bad,            // Corrupt this packet
    output logic      rx_pkt_valid,   // Packet ended
    output logic      rx_pkt_crc_err, // Packet corrupt
    output logic      tx_stall_done,  // STALL went out
    output logic      toggle_advance  // Good packet acked
);
    // Error line wiggles outside packets so a stale value never passes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_pkt_valid   <= 1'h0;
            rx_pkt_crc_err <= 1'h0;
            tx_stall_done  <= 1'h0;
            toggle_advance <= 1'h0;
        end else begin
            tx_stall_done  <= go & send_stall;
            rx_pkt_valid   <= go & ~send_stall;
            rx_pkt_crc_err <= go ? bad : ~rx_pkt_crc_err;
            toggle_advance <= go & ~send_stall & ~bad & accept_packet;
        end
    end
endmodule : usb_host_model

// ### tb/usb_out_endpoint_status_ctrl_bench.sv
`timescale 1ns/1ps
module usb_out_endpoint_status_ctrl_bench;
    logic        sys_clk = 1'h0;
    logic        rst = 1'h1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'h0;
    logic        avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, rx_pkt_valid, rx_pkt_crc_err, tx_stall_done;
    logic        toggle_advance, send_stall, data_toggle, iso_mode, accept_packet;
    logic        fifo_rd_ptr_reset, out_fifo_full, irq;
    logic        go = 1'h0;
    logic        bad = 1'h0;
    logic [31:0] q, v, en;
    logic [3:0]  be;
    int          errors = 0;
    int          checked = 0;

    usb_out_endpoint_status_ctrl #(.ADDR_W(8)) uut (.*);
    usb_host_model host (.*);

    always #2 sys_clk = ~sys_clk;

    task automatic summarize;
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("wrong value at %0t: saw %h, want %h", $time, s, e);
        end
    endtask : chk

    // Request held until waitrequest is sampled low at a rising edge, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int n;
        avs_address    <= a;
        avs_write      <= w;
        avs_read       <= ~w;
        avs_writedata  <= d;
        avs_byteenable <= b;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'h0) break;
        end
        if (n == 20) begin
            errors++;
            summarize();
        end
        // Read data taken at the same edge that sees waitrequest low
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read  <= 1'h0;
        @(posedge sys_clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d, 4'hF);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0, 4'hF);
        chk(q, e);
    endtask : rdc

    // One OUT transfer from the host, then let the flags settle
    task automatic pkt(input logic b);
        go  <= 1'h1;
        bad <= b;
        @(posedge sys_clk);
        go <= 1'h0;
        repeat (4) @(posedge sys_clk);
    endtask : pkt

    function automatic logic [31:0] lo(input logic ss, sr, de, ov, fu, rd);
        return {24'h0, 1'h0, ss, sr, 1'h0, de, ov, fu, rd};
    endfunction : lo

    initial begin
        void'($urandom(32'hDDFB));
        repeat (16) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        rdc(8'h14, 32'h0);
        // Stall request, stall sent, its interrupt
        wr(8'h28, 32'h7);
        wr(8'h14, 32'h20);
        chk(send_stall, 32'h1);
        pkt(1'h0);
        rdc(8'h14, lo(1, 1, 0, 0, 0, 0));
        chk(irq, 32'h1);
        wr(8'h14, 32'h0);
        rdc(8'h14, 32'h0);
        wr(8'h24, 32'h7);
        chk(irq, 32'h0);
        // Single buffer: one packet fills, flush empties
        pkt(1'h0);
        rdc(8'h14, lo(0, 0, 0, 0, 1, 1));
        chk(irq, 32'h1);
        chk(accept_packet, 32'h0);
        // Ready bit kept at one so only the flush releases the packet
        wr(8'h14, 32'h11);
        repeat (4) @(posedge sys_clk);
        rdc(8'h14, 32'h0);
        // Double buffer: flush releases only one of two
        wr(8'h18, 32'h80);
        pkt(1'h0);
        rdc(8'h14, lo(0, 0, 0, 0, 0, 1));
        pkt(1'h0);
        wr(8'h14, 32'h01);
        rdc(8'h14, lo(0, 0, 0, 0, 1, 1));
        wr(8'h14, 32'h11);
        repeat (4) @(posedge sys_clk);
        rdc(8'h14, lo(0, 0, 0, 0, 0, 1));
        wr(8'h14, 32'h0);
        repeat (4) @(posedge sys_clk);
        rdc(8'h14, 32'h0);
        // Iso: error flag, then overrun which only a zero write clears
        wr(8'h18, 32'h40);
        chk(iso_mode, 32'h1);
        pkt(1'h1);
        rdc(8'h14, lo(0, 0, 1, 0, 1, 1));
        pkt(1'h0);
        rdc(8'h14, lo(0, 0, 1, 1, 1, 1));
        wr(8'h14, 32'h04);
        repeat (4) @(posedge sys_clk);
        rdc(8'h14, lo(0, 0, 0, 1, 0, 0));
        wr(8'h14, 32'h0);
        rdc(8'h14, 32'h0);
        // Bulk drops an errored packet
        wr(8'h18, 32'h0);
        pkt(1'h1);
        rdc(8'h14, 32'h0);
        // Toggle steps on a good packet, clears only on a one
        wr(8'h14, 32'h80);
        pkt(1'h0);
        chk(data_toggle, 32'h1);
        wr(8'h14, 32'h01);
        chk(data_toggle, 32'h1);
        wr(8'h14, 32'h81);
        chk(data_toggle, 32'h0);
        rdc(8'h14, lo(0, 0, 0, 0, 1, 1));
        // Random enables with random lanes, plus unmapped reads
        en = 32'h7;
        for (int i = 0; i < 20; i++) begin
            v  = $urandom;
            be = 4'($urandom);
            bus(1'h1, 8'h28, v, be);
            if (be[0]) en = v & 32'h7;
            rdc(8'h28, en);
            rdc({4'hC, v[3:2], 2'h0}, 32'h0);
        end
        summarize();
    end
endmodule : usb_out_endpoint_status_ctrl_bench

// ### tb/usb_out_props.sv
`timescale 1ns/1ps
module usb_out_props #(
    parameter int ADDR_W = 8                    // Address width
)(
    input wire logic              sys_clk,          // Clock
    input wire logic              rst,              // Reset
    input wire logic [ADDR_W-1:0] avs_address,      // Address
    input wire logic              avs_read,         // Read
    input wire logic              avs_write,        // Write
    input wire logic [31:0]       avs_writedata,    // Write data
    input wire logic [3:0]        avs_byteenable,   // Lanes
    input wire logic [31:0]       avs_readdata,     // Read data
    input wire logic              avs_waitrequest,  // Wait
    input wire logic              toggle_advance,   // Toggle step
    input wire logic              send_stall,       // Stalling
    input wire logic              data_toggle,      // Toggle
    input wire logic              iso_mode,         // ISO
    input wire logic              accept_packet,    // Room
    input wire logic              fifo_rd_ptr_reset, // Rewind
    input wire logic              out_fifo_full,    // Full
    input wire logic              irq               // Interrupt
);
    logic wlo;
    logic whi;
    logic rlo;
    // Accepted accesses; lane 0 carries every field
    assign wlo = avs_write & ~avs_waitrequest & avs_byteenable[0] & (avs_address[7:2] == 6'h05);
    assign whi = avs_write & ~avs_waitrequest & avs_byteenable[0] & (avs_address[7:2] == 6'h06);
    assign rlo = avs_read & ~avs_waitrequest & (avs_address[7:2] == 6'h05);

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    toggle_clear_a: assert property (wlo && avs_writedata[7] |=> !data_toggle)
        else $error("toggle not cleared");
    toggle_step_a: assert property (toggle_advance && !(wlo && avs_writedata[7])
        |=> data_toggle != $past(data_toggle)) else $error("toggle did not step");
    strobe_read_a: assert property (rlo |-> !avs_readdata[7])
        else $error("clear strobe reads one");
    stall_set_a: assert property (wlo |=> send_stall == $past(avs_writedata[5]))
        else $error("stall request not taken");
    stall_hold_a: assert property (!wlo |=> $stable(send_stall))
        else $error("stall request moved");
    full_room_a: assert property (accept_packet != out_fifo_full)
        else $error("room and full disagree");
    rewind_pulse_a: assert property (fifo_rd_ptr_reset |=> !fifo_rd_ptr_reset)
        else $error("rewind longer than a cycle");
    iso_select_a: assert property (whi |=> iso_mode == $past(avs_writedata[6]))
        else $error("iso enable not taken");

    // Main scenarios reached
    cover property (send_stall && irq);
    cover property (fifo_rd_ptr_reset);
    cover property (iso_mode && out_fifo_full);
endmodule : usb_out_props

bind usb_out_endpoint_status_ctrl usb_out_props #(.ADDR_W(ADDR_W)) props_i (.*);
